// [design/ufc_pkg.sv]
// Constants and types shared by the software flow-control block
package ufc_pkg;
  localparam int UFC_CHAR_W = 8;
  localparam int UFC_CNT_W = 9;
  localparam int UFC_FIFO_DEPTH = 8;
  // Two-bit flow field encodings, shared by transmit and receive halves
  localparam logic [1:0] UFC_SET_NONE = 2'h0;
  localparam logic [1:0] UFC_SET_TWO = 2'h1;
  localparam logic [1:0] UFC_SET_ONE = 2'h2;
  localparam logic [1:0] UFC_SET_BOTH = 2'h3;
  // Upper threshold per receive trigger field, 64-byte mode
  localparam logic [8:0] UFC_UPPER_T0 = 9'h008;
  localparam logic [8:0] UFC_UPPER_T1 = 9'h010;
  localparam logic [8:0] UFC_UPPER_T2 = 9'h038;
  localparam logic [8:0] UFC_UPPER_T3 = 9'h03C;
  // Lower threshold per transmit trigger field, 64-byte mode
  localparam logic [8:0] UFC_LOWER_T0 = 9'h000;
  localparam logic [8:0] UFC_LOWER_T1 = 9'h008;
  localparam logic [8:0] UFC_LOWER_T2 = 9'h010;
  localparam logic [8:0] UFC_LOWER_T3 = 9'h038;
  // Arrivals between Xoff resends
  localparam logic [4:0] UFC_RESEND_N0 = 5'h01;
  localparam logic [4:0] UFC_RESEND_N1 = 5'h04;
  localparam logic [4:0] UFC_RESEND_N2 = 5'h08;
  localparam logic [4:0] UFC_RESEND_N3 = 5'h10;
  localparam logic UFC_KIND_XON = 1'b0;
  localparam logic UFC_KIND_XOFF = 1'b1;
  localparam logic UFC_RST_READY = 1'b1;
  localparam logic UFC_RST_OP1_N = 1'b1;

  typedef enum logic [1:0] {
    UFC_HOLD_NONE,
    UFC_HOLD_ON,
    UFC_HOLD_OFF
  } ufc_hold_t;
endpackage

// [design/ufc_flow_ctrl.sv]
// Xon/Xoff software flow control for one UART channel, with its data FIFO
`timescale 1ns/1ps

module ufc_fifo import ufc_pkg::*; #(
  parameter int WIDTH = UFC_CHAR_W,
  parameter int DEPTH = UFC_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [LW-1:0] level_out
);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [LW-1:0] count;
    logic valid;
    logic [WIDTH-1:0] data;
  } ufc_fifo_st_t;

  ufc_fifo_st_t s_q;
  ufc_fifo_st_t s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic wr;
  logic rd;

  assign in_ready_out = s_q.count != LW'(DEPTH);
  assign out_valid_out = s_q.valid;
  assign out_data_out = s_q.data;
  assign level_out = s_q.count;

  always_comb begin
    s_d = s_q;
    wr = in_valid_in && in_ready_out;
    rd = out_valid_out && out_ready_in;
    if (wr) begin
      s_d.wptr = (s_q.wptr == AW'(DEPTH - 1)) ? '0 : s_q.wptr + AW'(1);
    end
    if (rd) begin
      s_d.rptr = (s_q.rptr == AW'(DEPTH - 1)) ? '0 : s_q.rptr + AW'(1);
    end
    s_d.count = s_q.count + LW'(wr) - LW'(rd);
    s_d.valid = s_d.count != '0;
    // Registered head word; bypass a word landing in the head slot
    s_d.data = (wr && s_d.rptr == s_q.wptr) ? in_data_in : mem[s_d.rptr];
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (wr) begin
      mem[s_q.wptr] <= in_data_in;
    end
  end
endmodule

module ufc_flow_ctrl import ufc_pkg::*; #(
  parameter int DEPTH = UFC_FIFO_DEPTH,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] enhanced_feature_reg_in,
  input wire logic [1:0] rx_trigger_in,
  input wire logic [1:0] tx_trigger_in,
  input wire logic fifo_256_mode_in,
  input wire logic [8:0] flow_upper_threshold_in,
  input wire logic [8:0] flow_lower_threshold_in,
  input wire logic [8:0] rx_count_reg_in,
  input wire logic [7:0] xon1_char_in,
  input wire logic [7:0] xon2_char_in,
  input wire logic [7:0] xoff1_char_in,
  input wire logic [7:0] xoff2_char_in,
  input wire logic xon_any_in,
  input wire logic func_select_in,
  input wire logic user_output_one_in,
  input wire logic [1:0] xoff_resend_control_in,
  input wire logic special_char_en_in,
  input wire logic flow_irq_enable_in,
  input wire logic isr_read_in,
  input wire logic rx_char_valid_in,
  output logic rx_char_ready_out,
  input wire logic [7:0] rx_char_in,
  input wire logic rx_parity_err_in,
  output logic rx_data_valid_out,
  input wire logic rx_data_ready_in,
  output logic [7:0] rx_data_out,
  output logic flow_char_valid_out,
  input wire logic flow_char_ready_in,
  output logic [7:0] flow_char_out,
  output logic tx_halt_out,
  output logic tx_flow_xoff_out,
  output logic rx_flow_xoff_out,
  output logic flow_irq_out,
  output logic special_char_out,
  input wire logic tx_fifo_empty_in,
  input wire logic tx_fifo_space_in,
  output logic tx_empty_out,
  output logic thr_empty_out,
  output logic user_output_one_n_out
);
  typedef struct packed {
    ufc_hold_t held;
    logic [7:0] held_char;
    logic pend_valid;
    logic [7:0] pend_char;
    logic rx_ready;
    logic rx_xoff;
    logic irq;
    logic special;
    logic tx_xoff;
    logic [4:0] resend_cnt;
    logic req_pend;
    logic req_kind;
    logic tx_valid;
    logic tx_second;
    logic [7:0] tx_char;
    logic [7:0] tx_next;
    logic tx_empty;
    logic thr_empty;
    logic op1_n;
  } ufc_st_t;

  ufc_st_t s_q;
  ufc_st_t s_d;
  logic push, fifo_in_ready, take, cur_v, rx_en, pair, tx_en, xoff_ok;
  logic f_on, f_off, s_on, s_off, got_on, got_off, any_on, store;
  logic resend_en, req, req_kind;
  logic [7:0] push_data, cur_c, on_c, off_c;
  logic [8:0] upper, lower;
  logic [4:0] resend_n;
  logic [LW-1:0] fifo_level;

  ufc_fifo #(.WIDTH(UFC_CHAR_W), .DEPTH(DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_in_ready),
    .in_data_in(push_data),
    .out_valid_out(rx_data_valid_out),
    .out_ready_in(rx_data_ready_in),
    .out_data_out(rx_data_out),
    .level_out(fifo_level)
  );

  assign rx_char_ready_out = s_q.rx_ready;
  assign flow_char_valid_out = s_q.tx_valid;
  assign flow_char_out = s_q.tx_char;
  assign tx_halt_out = s_q.rx_xoff;
  // transmit state bit, no interrupt path
  assign tx_flow_xoff_out = s_q.tx_xoff;
  assign rx_flow_xoff_out = s_q.rx_xoff;
  assign flow_irq_out = s_q.irq;
  assign special_char_out = s_q.special;
  assign tx_empty_out = s_q.tx_empty;
  assign thr_empty_out = s_q.thr_empty;
  assign user_output_one_n_out = s_q.op1_n;

  // Thresholds and resend interval
  always_comb begin
    unique case (rx_trigger_in)
      2'h0: upper = UFC_UPPER_T0;
      2'h1: upper = UFC_UPPER_T1;
      2'h2: upper = UFC_UPPER_T2;
      2'h3: upper = UFC_UPPER_T3;
    endcase
    unique case (tx_trigger_in)
      2'h0: lower = UFC_LOWER_T0;
      2'h1: lower = UFC_LOWER_T1;
      2'h2: lower = UFC_LOWER_T2;
      2'h3: lower = UFC_LOWER_T3;
    endcase
    if (fifo_256_mode_in) begin
      upper = flow_upper_threshold_in;
      lower = flow_lower_threshold_in;
    end
    unique case (xoff_resend_control_in)
      2'h0: resend_n = UFC_RESEND_N0;
      2'h1: resend_n = UFC_RESEND_N1;
      2'h2: resend_n = UFC_RESEND_N2;
      2'h3: resend_n = UFC_RESEND_N3;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.special = 1'b0;
    push = 1'b0;
    push_data = 8'h00;
    got_on = 1'b0;
    got_off = 1'b0;
    any_on = 1'b0;
    store = 1'b0;
    req = 1'b0;
    req_kind = UFC_KIND_XON;
    take = rx_char_valid_in && s_q.rx_ready;
    cur_v = s_q.pend_valid || take;
    cur_c = s_q.pend_valid ? s_q.pend_char : rx_char_in;
    s_d.pend_valid = 1'b0;
    rx_en = enhanced_feature_reg_in[1:0] != UFC_SET_NONE;
    pair = enhanced_feature_reg_in[1:0] == UFC_SET_BOTH;
    on_c = (enhanced_feature_reg_in[1:0] == UFC_SET_TWO) ? xon2_char_in
                                                         : xon1_char_in;
    off_c = (enhanced_feature_reg_in[1:0] == UFC_SET_TWO) ? xoff2_char_in
                                                          : xoff1_char_in;
    xoff_ok = !(xon1_char_in == xoff1_char_in &&
                xon2_char_in == xoff2_char_in);
    f_on = cur_c == xon1_char_in;
    f_off = cur_c == xoff1_char_in && xoff_ok;
    s_on = cur_c == xon2_char_in;
    s_off = cur_c == xoff2_char_in && xoff_ok;
    // parity error does not disqualify a flow char
    if (cur_v && !rx_en) begin
      store = 1'b1;
    end else if (cur_v && !pair) begin
      if (cur_c == on_c) begin
        got_on = 1'b1;
      end else if (cur_c == off_c) begin
        if (s_q.rx_xoff && xon_any_in) begin
          any_on = 1'b1;
        end else begin
          got_off = 1'b1;
        end
      end else begin
        store = 1'b1;
        any_on = xon_any_in;
      end
      // second Xoff code is the special char
      if (special_char_en_in && cur_c == xoff2_char_in &&
          enhanced_feature_reg_in[1:0] == UFC_SET_ONE) begin
        s_d.special = 1'b1;
      end
    end else if (cur_v) begin
      if (s_q.held == UFC_HOLD_ON && s_on) begin
        got_on = 1'b1;
        s_d.held = UFC_HOLD_NONE;
      end else if (s_q.held == UFC_HOLD_OFF && s_off) begin
        got_off = 1'b1;
        s_d.held = UFC_HOLD_NONE;
      end else if (f_on || f_off) begin
        s_d.held = f_on ? UFC_HOLD_ON : UFC_HOLD_OFF;
        s_d.held_char = cur_c;
        any_on = xon_any_in;
      end else if (s_q.held != UFC_HOLD_NONE) begin
        push = 1'b1;
        push_data = s_q.held_char;
        s_d.held = UFC_HOLD_NONE;
        s_d.pend_valid = 1'b1;
        s_d.pend_char = cur_c;
      end else begin
        store = 1'b1;
        any_on = xon_any_in;
        s_d.special = special_char_en_in && s_off;
      end
    end
    if (store) begin
      push = 1'b1;
      push_data = cur_c;
    end
    if (got_off) begin
      s_d.rx_xoff = 1'b1;
    end
    if (got_on || any_on) begin
      s_d.rx_xoff = 1'b0;
    end
    if (!rx_en) begin
      s_d.rx_xoff = 1'b0;
      s_d.held = UFC_HOLD_NONE;
    end
    // clear on read or Xon, set wins
    if (isr_read_in || got_on) begin
      s_d.irq = 1'b0;
    end
    if (got_off && flow_irq_enable_in) begin
      s_d.irq = 1'b1;
    end
    // Three free words cover this cycle's push, a push next cycle and a flush after it
    s_d.rx_ready = !s_d.pend_valid && fifo_level < LW'(DEPTH - 2);

    // function select turns output one into resend enable
    resend_en = func_select_in && user_output_one_in;
    s_d.op1_n = func_select_in ? UFC_RST_OP1_N : !user_output_one_in;
    tx_en = enhanced_feature_reg_in[3:2] != UFC_SET_NONE;
    if (!tx_en) begin
      s_d.tx_xoff = 1'b0;
      s_d.resend_cnt = 5'h00;
    end else if (!s_q.tx_xoff && rx_count_reg_in > upper) begin
      s_d.tx_xoff = 1'b1;
      s_d.resend_cnt = 5'h00;
      req = 1'b1;
      req_kind = UFC_KIND_XOFF;
    // single Xon at the lower threshold
    end else if (s_q.tx_xoff && rx_count_reg_in == lower) begin
      s_d.tx_xoff = 1'b0;
      s_d.resend_cnt = 5'h00;
      req = 1'b1;
      req_kind = UFC_KIND_XON;
    end else if (s_q.tx_xoff && resend_en && take) begin
      if (s_q.resend_cnt + 5'h01 >= resend_n) begin
        s_d.resend_cnt = 5'h00;
        req = 1'b1;
        req_kind = UFC_KIND_XOFF;
      end else begin
        s_d.resend_cnt = s_q.resend_cnt + 5'h01;
      end
    end
    // A newer request replaces one not yet started
    if (req) begin
      s_d.req_pend = 1'b1;
      s_d.req_kind = req_kind;
    end
    if (s_q.tx_valid && flow_char_ready_in) begin
      s_d.tx_valid = s_q.tx_second;
      s_d.tx_second = 1'b0;
      s_d.tx_char = s_q.tx_next;
    end
    if (!s_d.tx_valid && s_d.req_pend) begin
      s_d.req_pend = 1'b0;
      s_d.tx_valid = 1'b1;
      s_d.tx_second = enhanced_feature_reg_in[3:2] == UFC_SET_BOTH;
      s_d.tx_next = s_d.req_kind ? xoff2_char_in : xon2_char_in;
      if (enhanced_feature_reg_in[3:2] == UFC_SET_TWO) begin
        s_d.tx_char = s_d.tx_next;
      end else begin
        s_d.tx_char = s_d.req_kind ? xoff1_char_in : xon1_char_in;
      end
    end
    // line status follows FIFO empty and space inputs only
    s_d.tx_empty = tx_fifo_empty_in;
    s_d.thr_empty = tx_fifo_space_in;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
      s_q.rx_ready <= UFC_RST_READY;
      s_q.op1_n <= UFC_RST_OP1_N;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (sys_rst_in);

  a_tx_disable_xon: assert property (
    !tx_en |=> !tx_flow_xoff_out)
    else $error("transmit flow state not Xon while disabled");
  a_xoff_on_upper: assert property (
    tx_en && !tx_flow_xoff_out && rx_count_reg_in > upper
    |=> tx_flow_xoff_out ##[0:3] flow_char_valid_out)
    else $error("Xoff not entered or queued above upper threshold");
  a_hold_until_lower: assert property (
    tx_en && tx_flow_xoff_out && rx_count_reg_in != lower
    |=> tx_flow_xoff_out)
    else $error("left local Xoff before lower threshold");
  a_rx_xoff_halts: assert property (
    take && !s_q.pend_valid && rx_en && !pair && !xon_any_in &&
    rx_char_in == off_c && rx_char_in != on_c
    |=> rx_flow_xoff_out && tx_halt_out)
    else $error("received Xoff did not halt transmit");
  a_equal_codes_xon: assert property (
    take && !s_q.pend_valid && rx_en && !pair && on_c == off_c &&
    rx_char_in == on_c |=> !rx_flow_xoff_out)
    else $error("equal codes not treated as Xon");
  a_irq_read_clear: assert property (
    isr_read_in && !got_off |=> !flow_irq_out)
    else $error("status read did not clear flow interrupt");
  a_line_status_pass: assert property (
    tx_halt_out |=> tx_empty_out == $past(tx_fifo_empty_in) &&
    thr_empty_out == $past(tx_fifo_space_in))
    else $error("halt disturbed transmit empty bits");
  a_flush_stalls: assert property (
    s_q.pend_valid |-> !rx_char_ready_out ##1 !s_q.pend_valid)
    else $error("flush of held char did not stall input");
  a_resend_bound: assert property (
    s_q.resend_cnt < resend_n || !resend_en)
    else $error("resend counter past interval");
  a_xon_clears_cnt: assert property (
    $fell(tx_flow_xoff_out) |-> s_q.resend_cnt == 5'h00)
    else $error("resend counter not cleared on Xon");

  c_xoff_sent: cover property (
    flow_char_valid_out && flow_char_ready_in && tx_flow_xoff_out);
  c_pair_xoff: cover property ($rose(rx_flow_xoff_out) && pair);
  c_fifo_full: cover property (!fifo_in_ready);
  c_flush: cover property (s_q.pend_valid);
endmodule

// [test/ufc_remote_model.sv]
// Remote UART model: sends characters and takes flow characters
`timescale 1ns/1ps
module ufc_remote_model (
  input wire logic clk_sys_in,
  input wire logic rx_char_ready_in,
  output logic rx_char_valid_out,
  output logic [7:0] rx_char_out,
  output logic rx_parity_err_out,
  input wire logic flow_char_valid_in,
  input wire logic [7:0] flow_char_in,
  output logic flow_char_ready_out
);
  logic [7:0] got_q[$];
  int slow = 0;
  int wait_n = 0;

  initial begin
    rx_char_valid_out = 1'b0;
    rx_char_out = 8'h00;
    rx_parity_err_out = 1'b0;
    flow_char_ready_out = 1'b0;
  end

  task automatic send(input logic [7:0] c);
    @(posedge clk_sys_in);
    #1;
    rx_char_valid_out = 1'b1;
    rx_char_out = c;
    rx_parity_err_out = ~rx_parity_err_out;
    do @(posedge clk_sys_in); while (rx_char_ready_in !== 1'b1);
    #1;
    rx_char_valid_out = 1'b0;
    // Released line shows the inverse, never a stale copy
    rx_char_out = ~c;
  endtask

  // Slow mode stalls ready for a set number of cycles
  always @(posedge clk_sys_in) begin
    if (flow_char_valid_in === 1'b1 && flow_char_ready_out === 1'b1)
      got_q.push_back(flow_char_in);
    #1;
    if (flow_char_ready_out === 1'b1 || flow_char_valid_in !== 1'b1) begin
      flow_char_ready_out = 1'b0;
      wait_n = 0;
    end else if (wait_n >= slow)
      flow_char_ready_out = 1'b1;
    else
      wait_n++;
  end
endmodule

// [test/uart_software_flow_control_bench.sv]
// Self-checking bench for the software flow-control block
`timescale 1ns/1ps
module uart_software_flow_control_bench;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] enhanced_feature_reg = 4'h0;
  logic [1:0] rtrig = 2'h0;
  logic [1:0] ttrig = 2'h0;
  logic [1:0] rsc = 2'h0;
  logic [8:0] cnt = 9'h000;
  logic m256 = 1'b0;
  logic [8:0] fut = 9'h0FF;
  logic [8:0] flt = 9'h010;
  logic [7:0] x1 = 8'h11;
  logic [7:0] x2 = 8'h12;
  logic [7:0] f1 = 8'h13;
  logic [7:0] f2 = 8'h14;
  logic xany = 1'b0;
  logic fsel = 1'b0;
  logic uop1 = 1'b0;
  logic spen = 1'b0;
  logic irqen = 1'b1;
  logic isrrd = 1'b0;
  logic rdrdy = 1'b0;
  logic tfe = 1'b0;
  logic tfs = 1'b0;
  logic rcv, rx_count_reg, rpe, rd_v, fv, fr, halt, tx_xoff, rx_xoff, irq;
  logic spc, tx_e, thr_e, uon;
  logic [7:0] rc, rd, fc;
  int error_cnt = 0;
  int num_checks = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  ufc_remote_model rem_u (.clk_sys_in(clk_sys_in), .rx_char_ready_in(rx_count_reg),
    .rx_char_valid_out(rcv), .rx_char_out(rc), .rx_parity_err_out(rpe),
    .flow_char_valid_in(fv), .flow_char_in(fc), .flow_char_ready_out(fr));

  ufc_flow_ctrl dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .enhanced_feature_reg_in(enhanced_feature_reg), .rx_trigger_in(rtrig),
    .tx_trigger_in(ttrig), .fifo_256_mode_in(m256),
    .flow_upper_threshold_in(fut), .flow_lower_threshold_in(flt),
    .rx_count_reg_in(cnt), .xon1_char_in(x1), .xon2_char_in(x2),
    .xoff1_char_in(f1), .xoff2_char_in(f2), .xon_any_in(xany),
    .func_select_in(fsel), .user_output_one_in(uop1),
    .xoff_resend_control_in(rsc), .special_char_en_in(spen),
    .flow_irq_enable_in(irqen), .isr_read_in(isrrd),
    .rx_char_valid_in(rcv), .rx_char_ready_out(rx_count_reg), .rx_char_in(rc),
    .rx_parity_err_in(rpe), .rx_data_valid_out(rd_v),
    .rx_data_ready_in(rdrdy), .rx_data_out(rd), .flow_char_valid_out(fv),
    .flow_char_ready_in(fr), .flow_char_out(fc), .tx_halt_out(halt),
    .tx_flow_xoff_out(tx_xoff), .rx_flow_xoff_out(rx_xoff),
    .flow_irq_out(irq), .special_char_out(spc), .tx_fifo_empty_in(tfe),
    .tx_fifo_space_in(tfs), .tx_empty_out(tx_e), .thr_empty_out(thr_e),
    .user_output_one_n_out(uon));

  task automatic chk(input string what, input logic [8:0] seen,
                     input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Field 10 first set, 01 second set, 11 both in order
  task automatic flow_exp(input logic [1:0] f, input logic [7:0] a,
                          input logic [7:0] b);
    chk("flows", 9'(rem_u.got_q.size()), f == 2'h3 ? 9'h002 : 9'h001);
    if (rem_u.got_q.size() > 0)
      chk("flow char", 9'(rem_u.got_q.pop_front()), 9'(f[1] ? a : b));
    if (f == 2'h3 && rem_u.got_q.size() > 0)
      chk("flow second", 9'(rem_u.got_q.pop_front()), 9'(b));
    rem_u.got_q.delete();
  endtask

  task automatic pop_exp(input logic [7:0] c);
    chk("data valid", 9'(rd_v), 9'h001);
    chk("data", 9'(rd), 9'(c));
    rdrdy = 1'b1;
    cyc(1);
    rdrdy = 1'b0;
    cyc(1);
  endtask

  task automatic t_reset();
    chk("ready", 9'(rx_count_reg), 9'h001);
    chk("op1 n", 9'(uon), 9'h001);
    chk("tx state", 9'(tx_xoff), 9'h000);
    chk("rx state", 9'(rx_xoff), 9'h000);
    uop1 = 1'b1;
    cyc(2);
    chk("op1 n on", 9'(uon), 9'h000);
    uop1 = 1'b0;
    $display("test reset done");
  endtask

  task automatic t_thresh();
    logic [8:0] up[4];
    logic [8:0] lo[4];
    logic [1:0] f;
    up = '{9'h008, 9'h010, 9'h038, 9'h03C};
    lo = '{9'h000, 9'h008, 9'h010, 9'h038};
    cnt = 9'h03D;
    cyc(8);
    chk("tx off", 9'(rem_u.got_q.size()), 9'h000);
    cnt = 9'h000;
    for (int i = 0; i < 4; i++) begin
      f = 2'((i % 3) + 1);
      rem_u.slow = i;
      enhanced_feature_reg = {f, 2'h0};
      rtrig = 2'(i);
      ttrig = 2'(i);
      cnt = up[i];
      cyc(8);
      chk("no xoff", 9'(rem_u.got_q.size()), 9'h000);
      cnt = up[i] + 9'h001;
      cyc(14);
      flow_exp(f, f1, f2);
      chk("tx xoff", 9'(tx_xoff), 9'h001);
      chk("no irq", 9'(irq), 9'h000);
      cnt = lo[i] + 9'h001;
      cyc(8);
      chk("no xon", 9'(rem_u.got_q.size()), 9'h000);
      cnt = lo[i];
      cyc(14);
      flow_exp(f, x1, x2);
      chk("tx xon", 9'(tx_xoff), 9'h000);
    end
    // programmed thresholds, upper kept above lower
    m256 = 1'b1;
    fut = 9'h0C8;
    flt = 9'h020;
    enhanced_feature_reg = 4'h8;
    cnt = 9'h0C8;
    cyc(8);
    chk("big no xoff", 9'(rem_u.got_q.size()), 9'h000);
    cnt = 9'h0C9;
    cyc(14);
    flow_exp(2'h2, f1, f2);
    cnt = 9'h020;
    cyc(14);
    flow_exp(2'h2, x1, x2);
    m256 = 1'b0;
    $display("test thresholds done");
  endtask

  task automatic t_rx_single();
    enhanced_feature_reg = 4'h2;
    tfe = 1'b1;
    tfs = 1'b1;
    irqen = 1'b0;
    rem_u.send(f1);
    chk("irq masked", 9'(irq), 9'h000);
    chk("masked xoff", 9'(rx_xoff), 9'h001);
    rem_u.send(x1);
    irqen = 1'b1;
    rem_u.send(f1);
    chk("rx xoff", 9'(rx_xoff), 9'h001);
    chk("halt", 9'(halt), 9'h001);
    chk("irq", 9'(irq), 9'h001);
    chk("thr empty", 9'(thr_e), 9'h001);
    chk("tx empty", 9'(tx_e), 9'h001);
    isrrd = 1'b1;
    cyc(1);
    isrrd = 1'b0;
    cyc(1);
    chk("irq read", 9'(irq), 9'h000);
    rem_u.send(f1);
    rem_u.send(x1);
    chk("rx xon", 9'(rx_xoff), 9'h000);
    chk("halt off", 9'(halt), 9'h000);
    chk("irq xon", 9'(irq), 9'h000);
    cyc(2);
    chk("none stored", 9'(rd_v), 9'h000);
    xany = 1'b1;
    rem_u.send(f1);
    rem_u.send(f1);
    chk("any xoff", 9'(rx_xoff), 9'h000);
    rem_u.send(f1);
    rem_u.send(8'h41);
    chk("any data", 9'(rx_xoff), 9'h000);
    xany = 1'b0;
    cyc(2);
    pop_exp(8'h41);
    rem_u.send(f1);
    f1 = x1;
    rem_u.send(x1);
    rem_u.send(x1);
    chk("equal codes", 9'(rx_xoff), 9'h000);
    f1 = 8'h13;
    spen = 1'b1;
    rem_u.send(f2);
    chk("special", 9'(spc), 9'h001);
    cyc(1);
    chk("special end", 9'(spc), 9'h000);
    spen = 1'b0;
    cyc(1);
    pop_exp(f2);
    $display("test single receive done");
  endtask

  task automatic t_rx_pair();
    enhanced_feature_reg = 4'h3;
    rem_u.send(f1);
    rem_u.send(f2);
    chk("pair xoff", 9'(rx_xoff), 9'h001);
    rem_u.send(x1);
    rem_u.send(x1);
    rem_u.send(x2);
    chk("dup first", 9'(rx_xoff), 9'h000);
    rem_u.send(x1);
    rem_u.send(f1);
    rem_u.send(x1);
    rem_u.send(f1);
    chk("alternate", 9'(rx_xoff), 9'h000);
    rem_u.send(f2);
    chk("alt end", 9'(rx_xoff), 9'h001);
    cyc(2);
    chk("none stored", 9'(rd_v), 9'h000);
    rem_u.send(x2);
    cyc(2);
    pop_exp(x2);
    rem_u.send(x1);
    rem_u.send(8'h41);
    cyc(2);
    pop_exp(x1);
    pop_exp(8'h41);
    chk("kept xoff", 9'(rx_xoff), 9'h001);
    xany = 1'b1;
    rem_u.send(x2);
    chk("any second", 9'(rx_xoff), 9'h000);
    cyc(2);
    pop_exp(x2);
    rem_u.send(f1);
    rem_u.send(f2);
    rem_u.send(f1);
    chk("any first", 9'(rx_xoff), 9'h000);
    rem_u.send(f2);
    chk("any pair", 9'(rx_xoff), 9'h001);
    xany = 1'b0;
    $display("test pair receive done");
  endtask

  task automatic t_resend();
    int n[4];
    n = '{1, 4, 8, 16};
    rem_u.slow = 0;
    enhanced_feature_reg = 4'h8;
    rtrig = 2'h0;
    ttrig = 2'h0;
    rdrdy = 1'b1;
    fsel = 1'b1;
    cyc(1);
    uop1 = 1'b1;
    cnt = 9'h009;
    cyc(8);
    flow_exp(2'h2, f1, f2);
    for (int k = 0; k < 4; k++) begin
      rsc = 2'(k);
      cyc(1);
      repeat (n[k] - 1) rem_u.send(8'h20);
      cyc(6);
      chk("early resend", 9'(rem_u.got_q.size()), 9'h000);
      rem_u.send(8'h20);
      cyc(6);
      flow_exp(2'h2, f1, f2);
    end
    cnt = 9'h000;
    cyc(8);
    flow_exp(2'h2, x1, x2);
    rem_u.send(8'h20);
    cyc(6);
    chk("xon no resend", 9'(rem_u.got_q.size()), 9'h000);
    uop1 = 1'b0;
    rdrdy = 1'b0;
    $display("test resend done");
  endtask

  initial begin
    repeat (2) @(posedge clk_sys_in);
    #1;
    sys_rst_in = 1'b0;
    t_reset();
    t_thresh();
    t_rx_single();
    t_rx_pair();
    t_resend();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    #200000;
    $display("FAIL watchdog expected done seen hang");
    error_cnt++;
    final_report();
  end
endmodule
